// ### bench/decimated_lane_frame_mapper_bench.sv
// Self-checking bench for the lane frame mapper
`timescale 1ns/1ps
module decimated_lane_frame_mapper_bench;
	import lane_mapper_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	mode_cfg_s modeCfg = '0;
	logic linkDown = 1'b1;
	frame_s samples = '0;
	frame_s held = '0;
	logic laneReady, sampleTick, sampleReady, frameStart, serMult40x, cfgError, overflow;
	logic [7:0] laneValid;
	wire [63:0] lanes;
	lane_format_e activeFormat;
	logic [1:0] stallMode = 2'h0;
	logic [31:0] seed = 32'hD9562407;
	logic [5:0] decs[9] = '{DEC_8, DEC_9, DEC_10, DEC_12, DEC_16, DEC_18, DEC_20, DEC_24, DEC_32};
	frame_s txQ[$];
	int n_mismatch = 0;
	int n_tests = 0;
	always #50 clock = ~clock;
	decimated_lane_frame_mapper #(.FIFO_WORDS(16)) DUT (.clock(clock), .arst_n(arst_n),
		.modeCfg(modeCfg), .linkDown(linkDown), .samples(samples), .sampleTick(sampleTick),
		.sampleReady(sampleReady), .laneReady(laneReady), .chanALane0(lanes[7:0]),
		.chanALane1(lanes[15:8]), .chanALane2(lanes[23:16]), .chanALane3(lanes[31:24]),
		.chanBLane0(lanes[39:32]), .chanBLane1(lanes[47:40]), .chanBLane2(lanes[55:48]),
		.chanBLane3(lanes[63:56]), .laneValid(laneValid), .frameStart(frameStart),
		.activeFormat(activeFormat), .serMult40x(serMult40x), .cfgError(cfgError),
		.overflow(overflow));
	lane_receiver_model RX (.clock(clock), .lanes(lanes), .laneValid(laneValid),
		.frameStart(frameStart), .laneReady(laneReady), .stallMode(stallMode));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] oct(input logic [15:0] x, input int j);
		return j[0] ? x[7:0] : x[15:8];
	endfunction
	// Expected {mask, lane3..lane0} of one group for octet j
	function automatic logic [35:0] expGroup(lane_format_e f, chan_words_s w, int j);
		case (f)
			FMT_8821: return {4'hF, oct(w.b2q, j), oct(w.b2i, j), oct(w.b1q, j), oct(w.b1i, j)};
			FMT_4841: return {4'h6, 8'h00, oct(j < 2 ? w.b2i : w.b2q, j),
				oct(j < 2 ? w.b1i : w.b1q, j), 8'h00};
			FMT_4211: return {4'h3, 16'h0000, w.b1i[7:0], w.b1i[15:8]};
			FMT_4222: return {4'h3, 16'h0000, oct(w.b1q, j), oct(w.b1i, j)};
			FMT_2221: return {4'h2, 16'h0000, oct(w.b1i, j), 8'h00};
			default: return {4'h2, 16'h0000, oct(j < 2 ? w.b1i : w.b1q, j), 8'h00};
		endcase
	endfunction
	task automatic chkLane(input logic [72:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected lanes at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkStat(input logic [4:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected status at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic setCfg(input logic cx, input logic [5:0] sel, dec);
		linkDown = 1'b1;
		modeCfg = '{cx, sel[5:4], sel[3:2], sel[1:0], dec};
		// Long enough that a new link never ticks within decimation 8 of the old one
		repeat (8) @(negedge clock);
	endtask
	task automatic doFmt(input logic cx, input logic [5:0] sel, dec, input lane_format_e f,
		input logic m, input int nOct, input logic [1:0] stall);
		logic [72:0] got;
		frame_s fr;
		logic [35:0] ea, eb;
		int n;
		setCfg(cx, sel, dec);
		chkStat({activeFormat, serMult40x, cfgError}, {f, m, 1'b0});
		txQ.delete();
		RX.rxQ.delete();
		stallMode = stall;
		linkDown = 1'b0;
		modeCfg = mode_cfg_s'(samples[12:0]);
		repeat (40 * dec) @(negedge clock);
		stallMode = 2'h0;
		repeat (20) @(negedge clock);
		linkDown = 1'b1;
		n = 0;
		while (RX.rxQ.size() >= nOct && txQ.size() > 0) begin
			fr = txQ.pop_front();
			for (int j = 0; j < nOct; j++) begin
				got = RX.rxQ.pop_front();
				ea = expGroup(f, fr.chanA, j);
				eb = expGroup(f, fr.chanB, j);
				chkLane(got, {j == 0, eb[35:32], ea[35:32], eb[31:0], ea[31:0]});
			end
			n++;
		end
		chkStat({4'h0, n >= 30}, 5'h01);
	endtask
	always @(negedge clock) begin
		seed = lfsr(seed);
		samples <= {samples[95:0], seed};
	end
	// A tick reports the take at the previous edge
	always @(posedge clock) begin
		if (sampleTick)
			txQ.push_back(held);
		held = samples;
	end
	initial begin
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		foreach (decs[i]) begin
			setCfg(1'b1, SEL_100, decs[i]);
			chkStat({4'h0, cfgError}, {4'h0, decs[i] > DEC_MAX_20X});
			setCfg(1'b1, SEL_200, decs[i]);
			chkStat({activeFormat, serMult40x, cfgError}, {FMT_4841, MULT_40X, 1'b0});
		end
		doFmt(1'b1, SEL_100, DEC_8, FMT_8821, MULT_20X, 2, 2'h0);
		doFmt(1'b1, SEL_200, DEC_32, FMT_4841, MULT_40X, 4, 2'h1);
		doFmt(1'b0, SEL_110, DEC_9, FMT_4211, MULT_20X, 1, 2'h1);
		doFmt(1'b0, SEL_100, DEC_20, FMT_4222, MULT_20X, 2, 2'h1);
		doFmt(1'b0, SEL_001, DEC_24, FMT_2221, MULT_40X, 2, 2'h0);
		doFmt(1'b0, SEL_200, DEC_12, FMT_2242, MULT_40X, 4, 2'h1);
		// Receiver held off until the 16-word buffer refuses
		setCfg(1'b1, SEL_100, DEC_8);
		stallMode = 2'h2;
		linkDown = 1'b0;
		repeat (240) @(negedge clock);
		chkStat({3'h0, sampleReady, overflow}, 5'h01);
		linkDown = 1'b1;
		stallMode = 2'h0;
		repeat (3) @(negedge clock);
		chkStat({4'h0, overflow}, 5'h00);
		print_verdict();
	end
	// Run needs about 5000 cycles; allow six times that
	initial begin
		#3000000;
		n_mismatch++;
		print_verdict();
	end
endmodule
bind decimated_lane_frame_mapper lane_mapper_monitor MON (.clock(clock), .arst_n(arst_n),
	.modeCfg(modeCfg), .linkDown(linkDown), .sampleTick(sampleTick),
	.chanALane0(chanALane0), .chanBLane0(chanBLane0), .laneValid(laneValid),
	.frameStart(frameStart), .activeFormat(activeFormat), .serMult40x(serMult40x),
	.cfgError(cfgError));

// ### bench/lane_mapper_monitor.sv
// Concurrent checks on the lane mapper ports
`timescale 1ns/1ps
module lane_mapper_monitor
	import lane_mapper_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Configuration
	input wire lane_mapper_pkg::mode_cfg_s modeCfg,
	input wire logic linkDown,
	// Outputs watched
	input wire logic sampleTick,
	input wire logic [7:0] chanALane0,
	input wire logic [7:0] chanBLane0,
	input wire logic [7:0] laneValid,
	input wire logic frameStart,
	input wire lane_mapper_pkg::lane_format_e activeFormat,
	input wire logic serMult40x,
	input wire logic cfgError
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_mult20;
		activeFormat inside {FMT_8821, FMT_4211, FMT_4222} |-> !serMult40x;
	endproperty
	a_mult20: assert property (p_mult20) else $error("20X format shows 40X");
	property p_mult40;
		activeFormat inside {FMT_4841, FMT_2221, FMT_2242} |-> serMult40x;
	endproperty
	a_mult40: assert property (p_mult40) else $error("40X format shows 20X");
	// Selector A of 1 never means a 40X format
	property p_rate;
		linkDown && modeCfg.laneFormatSelectA == 2'h1 && modeCfg.decim > DEC_MAX_20X
			|=> cfgError;
	endproperty
	a_rate: assert property (p_rate) else $error("20X lane rate over limit accepted");
	property p_8821;
		frameStart && activeFormat == FMT_8821 |-> laneValid == 8'hFF;
	endproperty
	a_8821: assert property (p_8821) else $error("eight lane mask wrong");
	property p_4841;
		frameStart && activeFormat == FMT_4841 |-> laneValid == 8'h66;
	endproperty
	a_4841: assert property (p_4841) else $error("four lane mask wrong");
	property p_real;
		frameStart && activeFormat inside {FMT_4211, FMT_4222, FMT_2221, FMT_2242}
			|-> laneValid == (activeFormat inside {FMT_2221, FMT_2242} ? 8'h22 : 8'h33);
	endproperty
	a_real: assert property (p_real) else $error("real lane mask wrong");
	property p_groups;
		laneValid[3:0] == laneValid[7:4];
	endproperty
	a_groups: assert property (p_groups) else $error("lane groups differ");
	property p_idle;
		laneValid == 8'h00 |-> chanALane0 == 8'h00 && chanBLane0 == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("idle lane not zero");
	property p_tick;
		sampleTick |=> !sampleTick [*7];
	endproperty
	a_tick: assert property (p_tick) else $error("samples closer than decimation 8");
	property p_frozen;
		!$past(linkDown) |-> $stable(activeFormat) && $stable(serMult40x) && $stable(cfgError);
	endproperty
	a_frozen: assert property (p_frozen) else $error("config moved with link up");
endmodule

// ### bench/lane_receiver_model.sv
// Receiver-side model: throttles laneReady and records lane octets
`timescale 1ns/1ps
module lane_receiver_model (
	// Clock
	input wire logic clock,
	// Lane side
	input wire logic [63:0] lanes,
	input wire logic [7:0] laneValid,
	input wire logic frameStart,
	output logic laneReady,
	// Mode: 0 ready, 1 random pauses, 2 held off
	input wire logic [1:0] stallMode
);
	logic [72:0] rxQ[$];
	logic [7:0] rnd = 8'hA5;
	initial laneReady = 1'b1;
	// Pauses kept to a quarter so the slowest frame still fits a sample period
	always @(negedge clock) begin
		rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
		laneReady = stallMode == 2'h0 || (stallMode == 2'h1 && rnd[1:0] != 2'h0);
	end
	always @(posedge clock)
		if (laneValid != 8'h00)
			rxQ.push_back({frameStart, laneValid, lanes});
endmodule

// ### rtl/decimated_lane_frame_mapper.sv
// Frame mapper placing decimated samples onto two groups of four lanes
//
// Overview of operation
// - Complex mode: two bands, decimation 8 to 32
// - Only formats within lane and sample rates
// - 8821 uses 20X with selectors 1,0,0
// - 4841 uses 40X, only choice above 20
// - 8821 lanes: b1I, b1Q, b2I, b2Q, MSB first
// - 4841 two lanes: band-1 IQ, band-2 IQ
// - Real formats 4211, 4222, 2221, 2242 mapping
// - Group A lanes channel A, group B B
// - Real formats use their listed multiplier, selectors
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Filling side
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	// Draining side
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [AW:0] count_reg, count_next;
	logic push, pop;
	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
		rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end

	// Storage needs no reset; emptiness is tracked by the count
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	assign inReady = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
endmodule

module decimated_lane_frame_mapper
	import lane_mapper_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Mode configuration, taken only while the link is down
	input wire lane_mapper_pkg::mode_cfg_s modeCfg,
	input wire logic linkDown,
	// Down-converter samples, taken once per decimated sample period
	input wire lane_mapper_pkg::frame_s samples,
	output logic sampleTick,
	output logic sampleReady,
	// Lane side toward the receiver
	input wire logic laneReady,
	output logic [7:0] chanALane0,
	output logic [7:0] chanALane1,
	output logic [7:0] chanALane2,
	output logic [7:0] chanALane3,
	output logic [7:0] chanBLane0,
	output logic [7:0] chanBLane1,
	output logic [7:0] chanBLane2,
	output logic [7:0] chanBLane3,
	output logic [7:0] laneValid,
	output logic frameStart,
	// Status
	output lane_mapper_pkg::lane_format_e activeFormat,
	output logic serMult40x,
	output logic cfgError,
	output logic overflow
);
	import lane_mapper_pkg::*;
	typedef enum logic {ST_IDLE, ST_SEND} send_state_e;
	function automatic logic decimOk(logic [DECIM_W-1:0] d);
		case (d)
			DEC_8, DEC_9, DEC_10, DEC_12, DEC_16, DEC_18, DEC_20, DEC_24, DEC_32:
				decimOk = 1'b1;
			default: decimOk = 1'b0;
		endcase
	endfunction
	function automatic lane_format_e decodeFmt(mode_cfg_s c);
		logic [5:0] sel;
		sel = {c.laneFormatSelectA, c.laneFormatSelectB, c.laneFormatSelectC};
		decodeFmt = FMT_NONE;
		if (c.complexMode) begin
			if (sel == SEL_100) decodeFmt = FMT_8821;
			if (sel == SEL_200) decodeFmt = FMT_4841;
		end else begin
			case (sel)
				SEL_110: decodeFmt = FMT_4211;
				SEL_100: decodeFmt = FMT_4222;
				SEL_001: decodeFmt = FMT_2221;
				SEL_200: decodeFmt = FMT_2242;
				default: decodeFmt = FMT_NONE;
			endcase
		end
	endfunction
	function automatic logic is40x(lane_format_e f);
		is40x = (f == FMT_4841) || (f == FMT_2221) || (f == FMT_2242);
	endfunction
	function automatic logic [3:0] laneMask(lane_format_e f);
		case (f)
			FMT_8821: laneMask = MASK_8821;
			FMT_4841: laneMask = MASK_4841;
			FMT_4211, FMT_4222: laneMask = MASK_REAL4;
			FMT_2221, FMT_2242: laneMask = MASK_REAL2;
			default: laneMask = 4'h0;
		endcase
	endfunction
	function automatic logic [1:0] lastOctet(lane_format_e f);
		case (f)
			FMT_4211: lastOctet = LAST_F1;
			FMT_4841, FMT_2242: lastOctet = LAST_F4;
			default: lastOctet = LAST_F2;
		endcase
	endfunction
	// Octet j of the frame on lane n of one channel
	function automatic logic [7:0] pickOctet(lane_format_e f, chan_words_s w,
			logic [1:0] n, logic [1:0] j);
		logic [63:0] flat;
		logic [1:0] idx;
		logic lower;
		logic [15:0] word;
		flat = w;
		idx = 2'h0;
		lower = j[0];
		case (f)
			FMT_8821: idx = n;
			FMT_4841: idx = {n[1], j[1]};
			FMT_4211: lower = n[0];
			FMT_4222: idx = {1'b0, n[0]};
			FMT_2242: idx = {1'b0, j[1]};
			default: idx = 2'h0;
		endcase
		word = flat[{idx, 4'h0} +: 16];
		pickOctet = lower ? word[7:0] : word[15:8];
	endfunction
	// Configuration, frozen while the link runs
	lane_format_e fmt_reg, fmt_next;
	logic [DECIM_W-1:0] dec_reg, dec_next;
	logic mult_reg, mult_next, err_reg, err_next;
	logic running;
	always_comb begin
		fmt_next = fmt_reg;
		dec_next = dec_reg;
		mult_next = mult_reg;
		err_next = err_reg;
		if (linkDown) begin
			fmt_next = decodeFmt(modeCfg);
			dec_next = modeCfg.decim;
			mult_next = is40x(decodeFmt(modeCfg)) ? MULT_40X : MULT_20X;
			// 20X formats overrun the lane rate above decimation 20
			err_next = !decimOk(modeCfg.decim) || decodeFmt(modeCfg) == FMT_NONE
				|| (!is40x(decodeFmt(modeCfg)) && modeCfg.decim > DEC_MAX_20X);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fmt_reg <= FMT_NONE;
			dec_reg <= DEC_RESET;
			mult_reg <= MULT_20X;
			err_reg <= 1'b1;
		end else begin
			fmt_reg <= fmt_next;
			dec_reg <= dec_next;
			mult_reg <= mult_next;
			err_reg <= err_next;
		end
	end
	assign running = !linkDown && !err_reg;
	// Decimated sample rate as a one-cycle enable
	logic [DECIM_W-1:0] decCnt_reg, decCnt_next;
	logic tick_reg, tick_next, ovf_reg, ovf_next;
	logic fifoInReady, fifoOutValid, fifoOutReady;
	frame_s fifoOut;
	always_comb begin
		decCnt_next = '0;
		tick_next = 1'b0;
		if (running) begin
			decCnt_next = (decCnt_reg == dec_reg - 1'b1) ? '0 : decCnt_reg + 1'b1;
			tick_next = (decCnt_reg == '0);
		end
		ovf_next = ovf_reg;
		if (linkDown) begin
			ovf_next = 1'b0;
		end
		// Set wins; a frame lost to a full buffer is always reported
		if (running && decCnt_reg == '0 && !fifoInReady) begin
			ovf_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			decCnt_reg <= '0;
			tick_reg <= 1'b0;
			ovf_reg <= 1'b0;
		end else begin
			decCnt_reg <= decCnt_next;
			tick_reg <= tick_next;
			ovf_reg <= ovf_next;
		end
	end

	sample_fifo #(
		.WIDTH($bits(frame_s)),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.clock(clock),
		.arst_n(arst_n),
		.inData(samples),
		.inValid(running && decCnt_reg == '0),
		.inReady(fifoInReady),
		.outData(fifoOut),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady)
	);
	// Framer: emits one octet per lane per cycle while the receiver is ready
	send_state_e state_reg, state_next;
	frame_s frame_reg, frame_next;
	logic [1:0] oct_reg, oct_next;
	logic [7:0] laneA [LANES];
	logic [7:0] laneB [LANES];
	logic [7:0] lanesA_reg [LANES];
	logic [7:0] lanesB_reg [LANES];
	logic [7:0] valid_reg, valid_next;
	logic start_reg, start_next, rdy_reg, emit, lastOct;
	logic [3:0] activeMask;
	always_comb begin
		state_next = state_reg;
		frame_next = frame_reg;
		oct_next = oct_reg;
		activeMask = laneMask(fmt_reg);
		emit = (state_reg == ST_SEND) && laneReady && running;
		lastOct = (oct_reg == lastOctet(fmt_reg));
		// Link down pops one buffered frame per cycle; a new link sends no stale frames if the link stayed down as many cycles as frames held
		fifoOutReady = linkDown
			|| (running && ((state_reg == ST_IDLE) || (emit && lastOct)));
		case (state_reg)
			ST_IDLE: begin
				if (running && fifoOutValid) begin
					state_next = ST_SEND;
					frame_next = fifoOut;
					oct_next = 2'h0;
				end
			end
			ST_SEND: begin
				if (!running) begin
					state_next = ST_IDLE;
				end else if (emit) begin
					oct_next = oct_reg + 1'b1;
					if (lastOct) begin
						oct_next = 2'h0;
						frame_next = fifoOut;
						state_next = fifoOutValid ? ST_SEND : ST_IDLE;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
		for (int n = 0; n < LANES; n++) begin
			// Both groups share one arrangement, each fed its own channel
			laneA[n] = emit && activeMask[n] ?
				pickOctet(fmt_reg, frame_reg.chanA, 2'(n), oct_reg) : 8'h00;
			laneB[n] = emit && activeMask[n] ?
				pickOctet(fmt_reg, frame_reg.chanB, 2'(n), oct_reg) : 8'h00;
		end
		valid_next = emit ? {activeMask, activeMask} : 8'h00;
		start_next = emit && (oct_reg == 2'h0);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			frame_reg <= '0;
			oct_reg <= 2'h0;
			valid_reg <= 8'h00;
			start_reg <= 1'b0;
			rdy_reg <= 1'b0;
			lanesA_reg <= '{default: 8'h00};
			lanesB_reg <= '{default: 8'h00};
		end else begin
			state_reg <= state_next;
			frame_reg <= frame_next;
			oct_reg <= oct_next;
			valid_reg <= valid_next;
			start_reg <= start_next;
			rdy_reg <= fifoInReady;
			lanesA_reg <= laneA;
			lanesB_reg <= laneB;
		end
	end
	assign chanALane0 = lanesA_reg[0];
	assign chanALane1 = lanesA_reg[1];
	assign chanALane2 = lanesA_reg[2];
	assign chanALane3 = lanesA_reg[3];
	assign chanBLane0 = lanesB_reg[0];
	assign chanBLane1 = lanesB_reg[1];
	assign chanBLane2 = lanesB_reg[2];
	assign chanBLane3 = lanesB_reg[3];
	assign laneValid = valid_reg;
	assign frameStart = start_reg;
	assign sampleTick = tick_reg;
	assign sampleReady = rdy_reg;
	assign activeFormat = fmt_reg;
	assign serMult40x = mult_reg;
	assign cfgError = err_reg;
	assign overflow = ovf_reg;
endmodule

// ### rtl/lane_mapper_pkg.sv
// Shared constants and types for the decimated lane frame mapper
package lane_mapper_pkg;
	localparam int SAMPLE_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int LANES = 4;
	localparam int DECIM_W = 6;
	// Selector codes packed as {select_a, select_b, select_c}, two bits each
	localparam logic [5:0] SEL_100 = 6'h10;
	localparam logic [5:0] SEL_200 = 6'h20;
	localparam logic [5:0] SEL_110 = 6'h14;
	localparam logic [5:0] SEL_001 = 6'h01;
	// Supported decimation factors
	localparam logic [5:0] DEC_8 = 6'h08;
	localparam logic [5:0] DEC_9 = 6'h09;
	localparam logic [5:0] DEC_10 = 6'h0A;
	localparam logic [5:0] DEC_12 = 6'h0C;
	localparam logic [5:0] DEC_16 = 6'h10;
	localparam logic [5:0] DEC_18 = 6'h12;
	localparam logic [5:0] DEC_20 = 6'h14;
	localparam logic [5:0] DEC_24 = 6'h18;
	localparam logic [5:0] DEC_32 = 6'h20;
	// Largest decimation that still keeps the 20X lane rate legal
	localparam logic [5:0] DEC_MAX_20X = 6'h14;
	localparam logic [5:0] DEC_RESET = 6'h08;
	localparam logic MULT_20X = 1'b0;
	localparam logic MULT_40X = 1'b1;
	// Lane masks and last octet index for frames of 1, 2 and 4 octets
	localparam logic [3:0] MASK_8821 = 4'hF;
	localparam logic [3:0] MASK_4841 = 4'h6;
	localparam logic [3:0] MASK_REAL4 = 4'h3;
	localparam logic [3:0] MASK_REAL2 = 4'h2;
	localparam logic [1:0] LAST_F1 = 2'h0;
	localparam logic [1:0] LAST_F2 = 2'h1;
	localparam logic [1:0] LAST_F4 = 2'h3;

	typedef enum logic [2:0] {
		FMT_NONE, FMT_8821, FMT_4841, FMT_4211, FMT_4222, FMT_2221, FMT_2242
	} lane_format_e;

	// Complex: b1i,b1q,b2i,b2q. Real: b1i is sample 0, b1q is sample 1.
	typedef struct packed {
		logic [SAMPLE_W-1:0] b2q;
		logic [SAMPLE_W-1:0] b2i;
		logic [SAMPLE_W-1:0] b1q;
		logic [SAMPLE_W-1:0] b1i;
	} chan_words_s;

	typedef struct packed {
		chan_words_s chanB;
		chan_words_s chanA;
	} frame_s;

	typedef struct packed {
		logic complexMode;
		logic [1:0] laneFormatSelectA;
		logic [1:0] laneFormatSelectB;
		logic [1:0] laneFormatSelectC;
		logic [DECIM_W-1:0] decim;
	} mode_cfg_s;
endpackage
